/* ccpc_channel.sv */
// Capture/compare/PWM channel with APB register access
`default_nettype none
// Behaviour
// - Duty held in buffer, loaded at period end
// - Ten-bit time base: timer plus two bits
// - Prescale 1:1 takes low bits from clock phase
// - Time base equals duty: output goes low
// - Resolution follows period value, ten bits at 255
// - Duty beyond period: output never cleared
// - Sleep freezes counting and channel state
// - Reset restores registers, output not driven
// - Control bit 7 enables channel, resets 0
// - Control bit 5 reads output, read-only
// - Alignment bit picks left or right duty
// - Mode field; active modes set event flag
// - Pulse modes, 1011 also clears timer
// - Toggle modes, 0001 also clears timer
// - Set/clear latch defaults when off
// - Capture on each, fall, rise, 4th, 16th edge
// - Timer pair select, reset 01
// - Three-bit capture source select
// - Period match: clear timer, set output unless new duty is zero, load buffer
// - Duty bit placement per alignment
// - Compare value against timer every cycle
// - Capture copies timer into value pair
module ccpc_channel
	import ccpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sleep_i,
	input wire logic [15:0] cc_timer1_i,
	input wire logic [15:0] cc_timer3_i,
	input wire logic [15:0] cc_timer5_i,
	output logic [2:0] cc_timer_clear_o,
	input wire logic [7:0] period_timer2_i,
	input wire logic [7:0] period_timer4_i,
	input wire logic [7:0] period_timer6_i,
	input wire logic [7:0] period_value2_i,
	input wire logic [7:0] period_value4_i,
	input wire logic [7:0] period_value6_i,
	input wire logic [2:0] period_inc_i,
	input wire logic [2:0] prescale_one_i,
	input wire logic [5:0] prescale_bits_i,
	input wire logic capture_pin_route_i,
	input wire logic [1:0] comparator_output_i,
	input wire logic pin_change_event_i,
	input wire logic [3:0] logic_cell_output_i,
	output logic channel_out_o,
	output logic channel_out_oe_o,
	output logic channel_event_o
);
	typedef struct packed {
		logic en;
		logic fmt;
		logic [3:0] mode;
		logic [1:0] tsel;
		logic [2:0] capsel;
		logic [7:0] vlow;
		logic [7:0] vhigh;
		logic [9:0] duty_buf;
		logic [1:0] phase;
		logic out;
		logic oe;
		logic evt;
		logic [2:0] sync;
		logic [3:0] edge_cnt;
		logic [3:0] mode_prev;
		logic [2:0] tclr;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} ccpc_state_t;

	ccpc_state_t st_q, st_d;

	// Word address decode, unmapped offsets answer with an error
	function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
		return (a[31:8] == 24'h0) && (a[7:0] == ofs);
	endfunction

	// One-hot clear for the selected pair, reserved code acts as the first pair
	function automatic logic [2:0] tsel_clear(input logic [1:0] t);
		case (t)
			2'h2: return 3'h2;
			2'h3: return 3'h4;
			default: return 3'h1;
		endcase
	endfunction

	logic [15:0] cc_tmr;
	logic [7:0] ptmr;
	logic [7:0] pval;
	logic pinc;
	logic [1:0] low_bits;
	logic [9:0] time_base;
	logic [9:0] tb_next;
	logic [9:0] duty_new;
	logic trig_src;
	logic is_pwm, is_cap, is_cmp;
	logic match;
	logic cap_fire;
	logic wr, rd;

	always_comb
	begin
		// Reserved pair code falls back to the first pair
		case (st_q.tsel)
			2'h2:
			begin
				cc_tmr = cc_timer3_i;
				ptmr = period_timer4_i;
				pval = period_value4_i;
				pinc = period_inc_i[1];
				low_bits = prescale_one_i[1] ? st_q.phase : prescale_bits_i[3:2];
			end
			2'h3:
			begin
				cc_tmr = cc_timer5_i;
				ptmr = period_timer6_i;
				pval = period_value6_i;
				pinc = period_inc_i[2];
				low_bits = prescale_one_i[2] ? st_q.phase : prescale_bits_i[5:4];
			end
			default:
			begin
				cc_tmr = cc_timer1_i;
				ptmr = period_timer2_i;
				pval = period_value2_i;
				pinc = period_inc_i[0];
				low_bits = prescale_one_i[0] ? st_q.phase : prescale_bits_i[1:0];
			end
		endcase
		time_base = {ptmr, low_bits};
		// Output is registered, so compare one step ahead
		tb_next = time_base + 10'h1;
		duty_new = st_q.fmt ? {st_q.vhigh, st_q.vlow[7:6]}
			: {st_q.vhigh[1:0], st_q.vlow};
		case (st_q.capsel)
			3'h0: trig_src = capture_pin_route_i;
			3'h1: trig_src = comparator_output_i[0];
			3'h2: trig_src = comparator_output_i[1];
			3'h3: trig_src = pin_change_event_i;
			default: trig_src = logic_cell_output_i[st_q.capsel[1:0]];
		endcase
	end

	// Change counts once second and third stages differ
	logic s_new, s_old;
	assign s_new = st_q.sync[1];
	assign s_old = st_q.sync[2];

	always_comb
	begin
		st_d = st_q;
		st_d.ready = 1'b0;
		st_d.err = 1'b0;
		st_d.tclr = 3'h0;
		st_d.evt = 1'b0;
		st_d.sync = {st_q.sync[1:0], trig_src};
		is_pwm = st_q.mode[3:2] == 2'h3;
		is_cap = (st_q.mode >= CCPC_M_CAPBOTH) && (st_q.mode <= CCPC_M_CAP16);
		is_cmp = st_q.en && !is_pwm && !is_cap && (st_q.mode != CCPC_M_OFF);
		match = is_cmp && (cc_tmr == {st_q.vhigh, st_q.vlow});
		cap_fire = 1'b0;
		wr = psel_i && penable_i && pwrite_i && !st_q.ready;
		rd = psel_i && penable_i && !pwrite_i && !st_q.ready;
		if (!sleep_i)
		begin
			// Realign on each timer step so low bits track the timer
			st_d.phase = pinc ? 2'h0 : st_q.phase + 2'h1;
			st_d.mode_prev = st_q.mode;
			if (!st_q.en || st_q.mode != st_q.mode_prev)
				st_d.edge_cnt = 4'h0;
			else if (is_cap && s_new && !s_old)
			begin
				st_d.edge_cnt = st_q.edge_cnt + 4'h1;
				case (st_q.mode)
					CCPC_M_CAPRISE: cap_fire = 1'b1;
					CCPC_M_CAPBOTH: cap_fire = 1'b1;
					CCPC_M_CAP4:
					begin
						cap_fire = st_q.edge_cnt[1:0] == CCPC_CAP4_CNT[1:0];
						st_d.edge_cnt = {2'h0, st_q.edge_cnt[1:0] + 2'h1};
					end
					CCPC_M_CAP16: cap_fire = st_q.edge_cnt == CCPC_CAP16_CNT;
					default: cap_fire = 1'b0;
				endcase
			end
			else if (is_cap && !s_new && s_old)
				cap_fire = st_q.mode == CCPC_M_CAPBOTH || st_q.mode == CCPC_M_CAPFALL;
			if (st_q.en && cap_fire)
			begin
				st_d.vhigh = cc_tmr[15:8];
				st_d.vlow = cc_tmr[7:0];
				st_d.evt = 1'b1;
			end
			if (match)
			begin
				st_d.evt = 1'b1;
				case (st_q.mode)
					CCPC_M_TOG: st_d.out = !st_q.out;
					CCPC_M_TOGCLR:
					begin
						st_d.out = !st_q.out;
						st_d.tclr = tsel_clear(st_q.tsel);
					end
					CCPC_M_SET: st_d.out = 1'b1;
					CCPC_M_CLR: st_d.out = 1'b0;
					CCPC_M_PULSE: st_d.out = 1'b1;
					CCPC_M_PULSECLR:
					begin
						st_d.out = 1'b1;
						st_d.tclr = tsel_clear(st_q.tsel);
					end
					default: st_d.out = st_q.out;
				endcase
			end
			else if (is_cmp && st_q.mode[3:1] == 3'h5)
				st_d.out = 1'b0; // Pulse lasts one cycle
			if (st_q.en && is_pwm)
			begin
				if (pinc && ptmr == pval)
				begin
					st_d.duty_buf = duty_new;
					st_d.out = duty_new != 10'h0;
					st_d.evt = 1'b1;
				end
				else if (tb_next == st_q.duty_buf)
					st_d.out = 1'b0;
			end
		end
		if (!st_q.en || st_q.mode == CCPC_M_OFF)
			st_d.out = 1'b0;
		st_d.oe = st_q.en && st_q.mode != CCPC_M_OFF && !is_cap;
		if (psel_i && penable_i && !st_q.ready)
		begin
			st_d.ready = 1'b1;
			st_d.rdata = 32'h0;
			if (hit(paddr_i, CCPC_OFS_CTRL))
			begin
				st_d.rdata = {24'h0, st_q.en, 1'b0, st_q.out, st_q.fmt, st_q.mode};
				if (wr)
				begin
					st_d.en = pwdata_i[CCPC_EN_BIT];
					st_d.fmt = pwdata_i[CCPC_FMT_BIT];
					st_d.mode = pwdata_i[3:0];
				end
			end
			else if (hit(paddr_i, CCPC_OFS_TSEL))
			begin
				st_d.rdata = {30'h0, st_q.tsel};
				if (wr)
					st_d.tsel = pwdata_i[1:0];
			end
			else if (hit(paddr_i, CCPC_OFS_CAPSEL))
			begin
				st_d.rdata = {29'h0, st_q.capsel};
				if (wr)
					st_d.capsel = pwdata_i[2:0];
			end
			else if (hit(paddr_i, CCPC_OFS_VLOW))
			begin
				st_d.rdata = {24'h0, st_q.vlow};
				if (wr && !(st_d.evt && is_cap))
					st_d.vlow = pwdata_i[7:0];
			end
			else if (hit(paddr_i, CCPC_OFS_VHIGH))
			begin
				st_d.rdata = {24'h0, st_q.vhigh};
				if (wr && !(st_d.evt && is_cap))
					st_d.vhigh = pwdata_i[7:0];
			end
			else if (hit(paddr_i, CCPC_OFS_STAT))
				st_d.rdata = {24'h0, 6'h0, st_q.oe, st_q.out};
			else
				st_d.err = 1'b1;
			if (rd)
				st_d.err = st_d.err;
		end
		if (sys_rst_i)
		begin
			st_d = '0;
			st_d.tsel = CCPC_TSEL_RST;
			st_d.capsel = CCPC_CAPSEL_RST;
		end
	end

	always_ff @(posedge clk_i)
	begin
		st_q <= st_d;
	end

	assign prdata_o = st_q.rdata;
	assign pready_o = st_q.ready;
	assign pslverr_o = st_q.err;
	assign channel_out_o = st_q.out;
	assign channel_out_oe_o = st_q.oe;
	assign channel_event_o = st_q.evt;
	assign cc_timer_clear_o = st_q.tclr;

	property p_reset_clear;
		@(posedge clk_i) sys_rst_i |=> !st_q.en && st_q.tsel == CCPC_TSEL_RST && !channel_out_oe_o;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
	property p_disable_low;
		@(posedge clk_i) disable iff (sys_rst_i) !st_q.en |=> !channel_out_o;
	endproperty
	a_disable_low: assert property (p_disable_low) else $error("output high while off");
	property p_sleep_freeze;
		@(posedge clk_i) disable iff (sys_rst_i)
		sleep_i && !(psel_i && penable_i) |=> st_q.phase == $past(st_q.phase);
	endproperty
	a_sleep_freeze: assert property (p_sleep_freeze) else $error("state moved in sleep");
	property p_match_event;
		@(posedge clk_i) disable iff (sys_rst_i) !sleep_i && match |=> channel_event_o;
	endproperty
	a_match_event: assert property (p_match_event) else $error("match lost event");
	property p_pulse_one;
		@(posedge clk_i) disable iff (sys_rst_i)
		st_q.en && st_q.mode == CCPC_M_PULSE && !sleep_i && !match |=> !channel_out_o;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
	property p_clear_timer;
		@(posedge clk_i) disable iff (sys_rst_i)
		!sleep_i && match && st_q.mode == CCPC_M_TOGCLR |=> cc_timer_clear_o != 3'h0;
	endproperty
	a_clear_timer: assert property (p_clear_timer) else $error("timer not cleared");
	property p_duty_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		!sleep_i && st_q.en && is_pwm && pinc && ptmr == pval |=> st_q.duty_buf == $past(duty_new);
	endproperty
	a_duty_load: assert property (p_duty_load) else $error("duty not loaded");
	property p_pwm_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
		!sleep_i && st_q.en && is_pwm && !(pinc && ptmr == pval) && tb_next == st_q.duty_buf
		|=> !channel_out_o;
	endproperty
	a_pwm_clear: assert property (p_pwm_clear) else $error("pwm not cleared");
	property p_apb_one;
		@(posedge clk_i) disable iff (sys_rst_i) pready_o |=> !pready_o;
	endproperty
	a_apb_one: assert property (p_apb_one) else $error("ready held");
	c_capture: cover property (@(posedge clk_i) is_cap && cap_fire && st_q.en);
	c_pwm_load: cover property (@(posedge clk_i) is_pwm && pinc && ptmr == pval);
	c_match: cover property (@(posedge clk_i) match);
endmodule
`default_nettype wire

/* ccpc_pkg.sv */
// Package: register map, fields and mode codes of the capture/compare/PWM channel
`default_nettype none
package ccpc_pkg;
	localparam logic [7:0] CCPC_OFS_CTRL = 8'h00;
	localparam logic [7:0] CCPC_OFS_TSEL = 8'h04;
	localparam logic [7:0] CCPC_OFS_CAPSEL = 8'h08;
	localparam logic [7:0] CCPC_OFS_VLOW = 8'h0c;
	localparam logic [7:0] CCPC_OFS_VHIGH = 8'h10;
	localparam logic [7:0] CCPC_OFS_STAT = 8'h14;
	localparam int CCPC_EN_BIT = 7;
	localparam int CCPC_OUT_BIT = 5;
	localparam int CCPC_FMT_BIT = 4;
	localparam logic [1:0] CCPC_TSEL_RST = 2'h1;
	localparam logic [2:0] CCPC_CAPSEL_RST = 3'h0;
	localparam logic [3:0] CCPC_M_OFF = 4'h0;
	localparam logic [3:0] CCPC_M_TOGCLR = 4'h1;
	localparam logic [3:0] CCPC_M_TOG = 4'h2;
	localparam logic [3:0] CCPC_M_CAPBOTH = 4'h3;
	localparam logic [3:0] CCPC_M_CAPFALL = 4'h4;
	localparam logic [3:0] CCPC_M_CAPRISE = 4'h5;
	localparam logic [3:0] CCPC_M_CAP4 = 4'h6;
	localparam logic [3:0] CCPC_M_CAP16 = 4'h7;
	localparam logic [3:0] CCPC_M_SET = 4'h8;
	localparam logic [3:0] CCPC_M_CLR = 4'h9;
	localparam logic [3:0] CCPC_M_PULSE = 4'ha;
	localparam logic [3:0] CCPC_M_PULSECLR = 4'hb;
	localparam logic [3:0] CCPC_CAP4_CNT = 4'h3;
	localparam logic [3:0] CCPC_CAP16_CNT = 4'hf;
endpackage
`default_nettype wire

/* ccpc_timer_model.sv */
// Timer and trigger model facing the capture/compare/PWM channel
`default_nettype none
module ccpc_timer_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [7:0] period_i,
	output logic [15:0] timer_o,
	output logic [7:0] ptimer_o,
	output logic inc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q = 2'h0;
	initial
	begin
		timer_o = 16'h0000;
		ptimer_o = 8'h00;
	end
	// Period timer steps once per four clocks, so clock phase matters
	assign inc_o = run_i && div_q == 2'h3;
	always @(posedge clk_i)
	begin
		if (clear_i)
			timer_o <= 16'h0000;
		else if (run_i)
			timer_o <= timer_o + 16'h0001;
		if (run_i)
			div_q <= div_q + 2'h1;
		if (inc_o)
			ptimer_o <= (ptimer_o == period_i) ? 8'h00 : ptimer_o + 8'h01;
	end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the capture/compare/PWM channel
`default_nettype none
module testbench
	import ccpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, rd;
	logic pready_o, pslverr_o, channel_out_o, channel_out_oe_o, channel_event_o, err, inc;
	logic run = 1'b0, tclr = 1'b0, sleep_i = 1'b0, hi, clrs;
	logic [2:0] cc_timer_clear_o, prescale_one_i = 3'h7;
	logic [5:0] prescale_bits_i = 6'h00;
	logic [7:0] src = 8'h00, pval = 8'h03, ptmr;
	logic [9:0] d;
	logic [15:0] tmr;
	logic [3:0] cmpm [6] = '{CCPC_M_TOGCLR, CCPC_M_TOG, CCPC_M_SET, CCPC_M_CLR, CCPC_M_PULSE,
		CCPC_M_PULSECLR};
	integer seed = 32'hc932409f, error_cnt = 0, cmp_count = 0, ev_n = 0, n, i, k, m, s, hc;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i)
		if (channel_event_o === 1'b1)
			ev_n++;
	ccpc_timer_model i_tmr (.clk_i, .run_i(run), .clear_i(tclr || cc_timer_clear_o != 3'h0),
		.period_i(pval), .timer_o(tmr), .ptimer_o(ptmr), .inc_o(inc));
	ccpc_channel i_dut (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .sleep_i, .cc_timer1_i(tmr), .cc_timer3_i(tmr),
		.cc_timer5_i(tmr), .cc_timer_clear_o, .period_timer2_i(ptmr), .period_timer4_i(ptmr),
		.period_timer6_i(ptmr), .period_value2_i(pval), .period_value4_i(pval),
		.period_value6_i(pval), .period_inc_i({3{inc}}), .prescale_one_i, .prescale_bits_i,
		.capture_pin_route_i(src[0]), .comparator_output_i(src[2:1]),
		.pin_change_event_i(src[3]), .logic_cell_output_i(src[7:4]), .channel_out_o,
		.channel_out_oe_o, .channel_event_o);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
`define CHK(g, e) chk(32'(g), 32'(e))
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= v;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		if (n >= 20)
			error_cnt++;
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// High cycles in 64 clocks, i.e. four periods of sixteen
	function automatic integer pwm_exp(input logic [9:0] dv);
		return (dv > 10'd16) ? 64 : 4 * dv;
	endfunction
	function automatic integer caps(input integer md, input integer np);
		return (md == 3) ? 2 * np : (md == 6) ? np / 4 : (md == 7) ? np / 16 : np;
	endfunction
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		apb(0, CCPC_OFS_CTRL, 0);
		`CHK(rd[7:0], 8'h00);
		apb(0, CCPC_OFS_TSEL, 0);
		`CHK(rd[1:0], CCPC_TSEL_RST);
		apb(0, CCPC_OFS_CAPSEL, 0);
		`CHK(rd[2:0], CCPC_CAPSEL_RST);
		apb(1, 32'h0000_0020, 32'h0000_00ff);
		`CHK(err, 1'b1);
		for (i = 0; i < 6; i++)
		begin
			m = 8 + ($random(seed) & 31);
			run <= 1'b0;
			tclr <= 1'b1;
			apb(1, CCPC_OFS_VLOW, m);
			tclr <= 1'b0;
			apb(1, CCPC_OFS_VHIGH, 0);
			apb(1, CCPC_OFS_CTRL, 32'h80 | cmpm[i]);
			ev_n = 0;
			hi = 0;
			clrs = 0;
			run <= 1'b1;
			repeat (m + 8)
			begin
				@(posedge clk_i);
				hi |= channel_out_o;
				clrs |= cc_timer_clear_o != 3'h0;
			end
			`CHK(ev_n != 0, 1'b1);
			`CHK(clrs, cmpm[i] == CCPC_M_TOGCLR || cmpm[i] == CCPC_M_PULSECLR);
			`CHK(hi, cmpm[i] != CCPC_M_CLR);
			apb(1, CCPC_OFS_CTRL, 32'h20);
			apb(0, CCPC_OFS_CTRL, 0);
			`CHK(rd[7:0], 8'h00);
			`CHK(channel_out_o, 1'b0);
		end
		run <= 1'b0;
		apb(1, CCPC_OFS_CTRL, 32'h85);
		src[0] <= 1'b1;
		repeat (8) @(posedge clk_i);
		apb(0, CCPC_OFS_VLOW, 0);
		`CHK(rd[7:0], tmr[7:0]);
		apb(0, CCPC_OFS_VHIGH, 0);
		`CHK(rd[7:0], tmr[15:8]);
		src[0] <= 1'b0;
		// Every source once, modes cycling; disable between restarts the divider
		for (s = 0; s < 8; s++)
		begin
			m = 3 + s % 5;
			apb(1, CCPC_OFS_CTRL, 0);
			apb(1, CCPC_OFS_CAPSEL, s);
			apb(1, CCPC_OFS_CTRL, 32'h80 | m);
			ev_n = 0;
			for (k = 0; k < 16; k++)
			begin
				src[s] <= 1'b1;
				repeat (3) @(posedge clk_i);
				src[s] <= 1'b0;
				repeat (3) @(posedge clk_i);
			end
			repeat (8) @(posedge clk_i);
			`CHK(ev_n, caps(m, 16));
		end
		run <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			d = (i == 0) ? 10'h000 : (i == 3) ? 10'h3ff : 10'(1 + ($random(seed) & 7));
			apb(1, CCPC_OFS_VLOW, (i == 2) ? {d[1:0], 6'h00} : d[7:0]);
			apb(1, CCPC_OFS_VHIGH, (i == 2) ? d[9:2] : {6'h00, d[9:8]});
			apb(1, CCPC_OFS_CTRL, (i == 2) ? 32'h9c : 32'h8c);
			repeat (40) @(posedge clk_i);
			hc = 0;
			repeat (64)
			begin
				@(posedge clk_i);
				hc += (channel_out_o === 1'b1);
			end
			`CHK(hc, pwm_exp(d));
		end
		apb(0, CCPC_OFS_STAT, 0);
		`CHK(rd[1:0], 2'h3);
		sleep_i <= 1'b1;
		run <= 1'b0;
		repeat (2) @(posedge clk_i);
		ev_n = 0;
		repeat (20) @(posedge clk_i);
		`CHK(channel_out_o, 1'b1);
		`CHK(ev_n, 0);
		sleep_i <= 1'b0;
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		`CHK(channel_out_oe_o, 1'b0);
		apb(0, CCPC_OFS_CTRL, 0);
		`CHK(rd[7:0], 8'h00);
		print_verdict();
	end
	initial
	begin
		#400000;
		error_cnt++;
		print_verdict();
	end
endmodule
`default_nettype wire
